/* File: src/uart_status_pkg.sv */
// Package of offsets, field positions and reset values for the serial status block
package uart_status_pkg;
    // Register offsets (I/O addresses)
    localparam logic [9:0] LINE_STATUS_ADDR  = 10'h2fd;
    localparam logic [9:0] MODEM_STATUS_ADDR = 10'h2fe;
    localparam logic [9:0] SCRATCH_ADDR      = 10'h2ff;
    localparam logic [9:0] RX_DATA_ADDR      = 10'h2f8;
    localparam logic [9:0] TX_DATA_ADDR      = 10'h2f8;
    localparam logic [9:0] INT_ID_ADDR       = 10'h2fa;
    // Line status field positions
    localparam int LS_READY   = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY  = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK   = 4;
    localparam int LS_THR_MT  = 5;
    localparam int LS_TX_MT   = 6;
    localparam int LS_FIFO_ER = 7;
    // Modem status field positions
    localparam int MS_D_CTS = 0;
    localparam int MS_D_DSR = 1;
    localparam int MS_T_RI  = 2;
    localparam int MS_D_DCD = 3;
    // Modem control field positions used in loopback
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    // Interrupt enable bit for modem status
    localparam int IE_MODEM = 3;
    // Reset values
    localparam logic [7:0] SCRATCH_RST = 8'h00;
    localparam logic [7:0] DELTA_RST   = 8'h00;
    // Receive entry layout: data, parity, framing, break
    localparam int ENTRY_W = 11;
    localparam int E_PAR   = 8;
    localparam int E_FRM   = 9;
    localparam int E_BRK   = 10;
endpackage

/* File: src/uart_line_modem_status.sv */
// Line and modem status logic of the serial port, with its receive FIFO
//
// Function
// [RQ1] Legacy: holding empty set, cleared on write
// [RQ2] FIFO mode: holding empty only when empty
// [RQ3] FIFO: empty interrupt cleared by write/ID read
// [RQ4] Legacy: break flag after long spacing
// [RQ5] FIFO: one break entry per break
// [RQ6] After break, wait for valid start bit; the code waits in FIFO mode only, legacy mode still loads every character
// [RQ7] Framing error flag, FIFO reports at top
// [RQ8] Parity error flag, FIFO reports at top
// [RQ9] FIFO: error flags latched until status read
// [RQ10] Legacy: overrun when unread character overwritten
// [RQ11] FIFO: overrun when full, FIFO kept intact
// [RQ12] Data ready set on load, cleared on read
// [RQ13] Error bits valid regardless of interrupt enable
// [RQ14] Modem bits 7-4 show live input levels
// [RQ15] Loopback: modem bits from control bits
// [RQ16] Delta flags on any carrier/ready/clear change
// [RQ17] Ring flag only on trailing edge
// [RQ18] Modem interrupt while deltas set and enabled
// [RQ19] Modem status read clears deltas, interrupt
// [RQ20] Loopback: RTS to CTS, DTR to DSR
// [RQ21] FIFO enable selects legacy or FIFO mode
// [RQ22] Synchronise modem inputs before edge compare
// Synchronous FIFO of flip-flops, valid and ready on both sides
module status_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;
    // Honest flags straight from the occupancy count
    assign empty     = (cnt_r == '0);
    assign full      = (cnt_r == (AW+1)'(DEPTH));
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    // Storage written only on an accepted push
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_r[wr_r] <= in_data;
    end
    // Pointers and count
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else if (clear)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
// Status logic top
module uart_line_modem_status
    import uart_status_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [9:0] io_addr,
    input  wire logic       io_rd,
    input  wire logic       io_wr,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       fifo_mode_enable,
    input  wire logic       rx_fifo_clear,
    input  wire logic       tx_fifo_clear,
    input  wire logic [7:0] interrupt_enable_reg,
    input  wire logic [4:0] modem_ctrl,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char_data,
    input  wire logic       rx_parity_bad,
    input  wire logic       rx_stop_bad,
    input  wire logic       rx_break_seen,
    input  wire logic       rx_start_valid,
    input  wire logic       tx_shift_empty,
    input  wire logic       tx_load_take,
    output logic      [7:0] tx_load_data,
    output logic            tx_load_valid,
    input  wire logic       dcd_in,
    input  wire logic       ri_in,
    input  wire logic       dsr_in,
    input  wire logic       cts_in,
    output logic            tx_empty_irq,
    output logic            modem_irq,
    output logic            line_irq
);
    logic [ENTRY_W-1:0] rx_entry;
    logic [ENTRY_W-1:0] rx_top;
    logic               rx_push;
    logic               rx_valid;
    logic               rx_pop;
    logic               rx_full;
    logic               tx_push;
    logic               tx_fifo_valid;
    logic [7:0]         tx_fifo_data;
    logic               tx_empty;
    logic               rd_line;
    logic               rd_modem;
    logic               rd_rx;
    logic               wr_tx;
    logic               rd_intid;
    logic               loopback;
    logic [7:0]         scratch_r;
    logic [7:0]         rbr_r;
    logic               ready_r;
    logic               thr_full_r;
    logic [7:0]         thr_r;
    logic               ovr_r;
    logic               par_r;
    logic               frm_r;
    logic               brk_r;
    logic               break_hold_r;
    logic               tx_holding_empty_irq_r;
    logic [3:0]         modem_s1_r;
    logic [3:0]         modem_s2_r;
    logic [3:0]         modem_prev_r;
    logic [3:0]         modem_live;
    logic [3:0]         delta_r;
    logic [3:0]         delta_set;
    logic               thr_empty;
    logic [7:0]         line_stat;
    // Access decode
    assign rd_line  = io_rd && (io_addr == LINE_STATUS_ADDR);
    assign rd_modem = io_rd && (io_addr == MODEM_STATUS_ADDR);
    assign rd_rx    = io_rd && (io_addr == RX_DATA_ADDR);
    assign wr_tx    = io_wr && (io_addr == TX_DATA_ADDR);
    assign rd_intid = io_rd && (io_addr == INT_ID_ADDR);
    assign loopback = modem_ctrl[4];
    // Receive path: one entry per character, nothing while a break holds
    assign rx_entry = {rx_break_seen, rx_stop_bad, rx_parity_bad, rx_char_data};
    assign rx_push  = fifo_mode_enable && rx_char_valid && !break_hold_r; // [RQ5] [RQ6]
    assign rx_pop   = fifo_mode_enable && rd_rx;
    status_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clear     (rx_fifo_clear || !fifo_mode_enable),
        .in_valid  (rx_push),
        .in_ready  (),
        .in_data   (rx_entry),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_top),
        .empty     (),
        .full      (rx_full)
    );
    // Transmit FIFO drained by the transmit shifter, which can stall it
    assign tx_push = fifo_mode_enable && wr_tx;
    status_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clear     (tx_fifo_clear || !fifo_mode_enable),
        .in_valid  (tx_push),
        .in_ready  (),
        .in_data   (io_wdata),
        .out_valid (tx_fifo_valid),
        .out_ready (tx_load_take),
        .out_data  (tx_fifo_data),
        .empty     (tx_empty),
        .full      ()
    );
    // Shifter sees the FIFO head, or the holding register in legacy mode
    assign tx_load_valid = fifo_mode_enable ? tx_fifo_valid : thr_full_r; // [RQ21]
    assign tx_load_data  = fifo_mode_enable ? tx_fifo_data : thr_r;
    // Break hold: one break entry, then wait for a fresh start bit
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            break_hold_r <= 1'b0;
        else if (rx_start_valid)
            break_hold_r <= 1'b0;                                      // [RQ6]
        else if (rx_char_valid && rx_break_seen)
            break_hold_r <= 1'b1;                                      // [RQ5]
    end
    // Legacy receive buffer and data ready
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rbr_r   <= 8'h00;
            ready_r <= 1'b0;
        end
        else if (!fifo_mode_enable && rx_char_valid)
        begin
            rbr_r   <= rx_char_data;
            ready_r <= 1'b1;                                           // [RQ12]
        end
        else if (!fifo_mode_enable && rd_rx)
            ready_r <= 1'b0;                                           // [RQ12]
    end
    // Legacy holding register; full until the shifter takes it
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            thr_full_r <= 1'b0;
            thr_r      <= 8'h00;
        end
        else if (fifo_mode_enable)
            thr_full_r <= 1'b0;
        else if (wr_tx)
        begin
            thr_full_r <= 1'b1;                                        // [RQ1]
            thr_r      <= io_wdata;
        end
        else if (tx_load_take)
            thr_full_r <= 1'b0;                                        // [RQ1]
    end
    // Holding empty meaning depends on mode
    assign thr_empty = fifo_mode_enable ? tx_empty : !thr_full_r;     // [RQ1] [RQ2] [RQ21]
    // Transmitter-empty interrupt: a new empty event wins over a clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            tx_holding_empty_irq_r <= 1'b0;
        else if (thr_empty && !$past(thr_empty))
            tx_holding_empty_irq_r <= 1'b1;
        else if (wr_tx || rd_intid)
            tx_holding_empty_irq_r <= 1'b0;                                        // [RQ3]
    end
    assign tx_empty_irq = tx_holding_empty_irq_r && interrupt_enable_reg[1];       // [RQ3]
    // Error flags: legacy sets on arrival; FIFO mode sets overrun on arrival when full, the others on the top entry
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ovr_r <= 1'b0;
            par_r <= 1'b0;
            frm_r <= 1'b0;
            brk_r <= 1'b0;
        end
        else
        begin
            if (!fifo_mode_enable && rx_char_valid && ready_r && !rd_rx)
                ovr_r <= 1'b1;                                         // [RQ10]
            else if (fifo_mode_enable && rx_char_valid && rx_full)
                ovr_r <= 1'b1;                                         // [RQ11]
            else if (rd_line)
                ovr_r <= 1'b0;
            if (fifo_mode_enable ? (rx_valid && rx_top[E_PAR])
                                 : (rx_char_valid && rx_parity_bad))
                par_r <= 1'b1;                                         // [RQ8]
            else if (rd_line)
                par_r <= 1'b0;                                         // [RQ9]
            if (fifo_mode_enable ? (rx_valid && rx_top[E_FRM])
                                 : (rx_char_valid && rx_stop_bad))
                frm_r <= 1'b1;                                         // [RQ7]
            else if (rd_line)
                frm_r <= 1'b0;                                         // [RQ9]
            if (fifo_mode_enable ? (rx_valid && rx_top[E_BRK])
                                 : (rx_char_valid && rx_break_seen))
                brk_r <= 1'b1;                                         // [RQ4] [RQ5]
            else if (rd_line)
                brk_r <= 1'b0;                                         // [RQ9]
        end
    end
    // Line status image; error bits valid without interrupt enable
    always_comb
    begin
        line_stat[LS_READY]   = fifo_mode_enable ? rx_valid : ready_r; // [RQ12]
        line_stat[LS_OVERRUN] = ovr_r;                                 // [RQ13]
        line_stat[LS_PARITY]  = par_r;
        line_stat[LS_FRAMING] = frm_r;
        line_stat[LS_BREAK]   = brk_r;
        line_stat[LS_THR_MT]  = thr_empty;
        line_stat[LS_TX_MT]   = thr_empty && tx_shift_empty;
        line_stat[LS_FIFO_ER] = fifo_mode_enable && rx_valid
                                && (|rx_top[E_BRK:E_PAR]);
    end
    assign line_irq = interrupt_enable_reg[2] && (|line_stat[4:1]);   // [RQ13]
    // Modem inputs: loopback routes control bits, pins isolated
    logic [3:0] modem_src;
    assign modem_src = loopback ? {modem_ctrl[MC_OUT2], modem_ctrl[MC_OUT1],
                                   modem_ctrl[MC_DTR], modem_ctrl[MC_RTS]}  // [RQ15] [RQ20]
                                : {dcd_in, ri_in, dsr_in, cts_in};
    // Two-stage synchroniser, then the previous-value register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            modem_s1_r   <= 4'h0;
            modem_s2_r   <= 4'h0;
            modem_prev_r <= 4'h0;
        end
        else
        begin
            modem_s1_r   <= modem_src;                                 // [RQ22]
            modem_s2_r   <= modem_s1_r;
            modem_prev_r <= modem_s2_r;
        end
    end
    assign modem_live = modem_s2_r;                                    // [RQ14]
    // Change detect: order is dcd, ri, dsr, cts
    assign delta_set[MS_D_CTS] = modem_live[0] ^ modem_prev_r[0];      // [RQ16]
    assign delta_set[MS_D_DSR] = modem_live[1] ^ modem_prev_r[1];      // [RQ16]
    assign delta_set[MS_T_RI]  = !modem_live[2] && modem_prev_r[2];    // [RQ17]
    assign delta_set[MS_D_DCD] = modem_live[3] ^ modem_prev_r[3];      // [RQ16]
    // Deltas: a change in the read cycle survives the clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            delta_r <= DELTA_RST[3:0];
        else if (rd_modem)
            delta_r <= delta_set;                                      // [RQ19]
        else
            delta_r <= delta_r | delta_set;
    end
    assign modem_irq = interrupt_enable_reg[IE_MODEM] && (|delta_r);   // [RQ18]
    // Scratch byte
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            scratch_r <= SCRATCH_RST;
        else if (io_wr && io_addr == SCRATCH_ADDR)
            scratch_r <= io_wdata;
    end
    // Read data mux
    always_comb
    begin
        if (io_addr == LINE_STATUS_ADDR)
            io_rdata = line_stat;
        else if (io_addr == MODEM_STATUS_ADDR)
            io_rdata = {modem_live, delta_r};                          // [RQ14]
        else if (io_addr == SCRATCH_ADDR)
            io_rdata = scratch_r;
        else if (io_addr == RX_DATA_ADDR)
            io_rdata = fifo_mode_enable ? rx_top[7:0] : rbr_r;
        else
            io_rdata = 8'h00;
    end
endmodule

/* File: verification/status_asserts.sv */
// Concurrent checks on the ports of the serial status block
module status_checker
    import uart_status_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic [9:0] io_addr,
    input wire logic       io_rd,
    input wire logic       io_wr,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] interrupt_enable_reg,
    input wire logic [4:0] modem_ctrl,
    input wire logic       dcd_in,
    input wire logic       ri_in,
    input wire logic       dsr_in,
    input wire logic       cts_in,
    input wire logic       tx_load_valid,
    input wire logic       modem_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pins;
    logic       msr_sel;

    // Pin group in status bit order, and the status address decode
    assign pins = {dcd_in, ri_in, dsr_in, cts_in};
    assign msr_sel = io_addr == MODEM_STATUS_ADDR;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Both sides decode delta_r without a register, so they agree in each cycle that msr_sel is high
    irq_follows_a: assert property (
        msr_sel |-> modem_irq == (interrupt_enable_reg[IE_MODEM] && io_rdata[3:0] != 4'h0))
        else $error("modem interrupt disagrees with flags");
    irq_masked_a: assert property (
        !interrupt_enable_reg[IE_MODEM] |-> !modem_irq)
        else $error("modem interrupt while masked");
    // Quiet pins for six cycles: nothing left in the synchroniser
    read_clears_a: assert property (
        ($stable({pins, modem_ctrl}))[*6] ##0 (io_rd && msr_sel) |=> !modem_irq)
        else $error("modem status read left interrupt");
    live_levels_a: assert property (
        (!modem_ctrl[4] && $stable({pins, modem_ctrl}))[*5] ##0 msr_sel
        |-> io_rdata[7:4] == pins)
        else $error("live modem bits wrong");
    loop_map_a: assert property (
        (modem_ctrl[4] && $stable(modem_ctrl))[*5] ##0 msr_sel |-> io_rdata[7:4] ==
        {modem_ctrl[MC_OUT2], modem_ctrl[MC_OUT1], modem_ctrl[MC_DTR], modem_ctrl[MC_RTS]})
        else $error("loopback modem bits wrong");
    carrier_delta_a: assert property (
        ($changed(dcd_in) && !modem_ctrl[4] && $stable(modem_ctrl) && !io_rd)
        ##1 (msr_sel && !io_rd)[*6] |-> io_rdata[MS_D_DCD])
        else $error("carrier change not flagged");
    ring_rise_a: assert property (
        ($rose(ri_in) && !modem_ctrl[4] && msr_sel && !io_rdata[MS_T_RI] && !io_rd)
        ##1 (msr_sel && !io_rd)[*6] |-> !io_rdata[MS_T_RI])
        else $error("ring flag on leading edge");
    tx_write_a: assert property (
        io_wr && io_addr == TX_DATA_ADDR |=> tx_load_valid)
        else $error("written byte not offered");
    tx_holding_empty_busy_a: assert property (
        io_addr == LINE_STATUS_ADDR && tx_load_valid |-> !io_rdata[LS_THR_MT])
        else $error("holding empty while bytes wait");
endmodule

/* File: verification/modem_partner.sv */
// Behavioural remote serial device: modem lines and received characters
module modem_partner
(
    input  wire logic       clk_sys,
    output logic            dcd_in,
    output logic            ri_in,
    output logic            dsr_in,
    output logic            cts_in,
    output logic            rx_char_valid,
    output logic      [7:0] rx_char_data,
    output logic            rx_parity_bad,
    output logic            rx_stop_bad,
    output logic            rx_break_seen,
    output logic            rx_start_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet line at time zero
    initial
    begin
        {dcd_in, ri_in, dsr_in, cts_in} = 4'h0;
        {rx_char_valid, rx_start_valid} = 2'b00;
        {rx_break_seen, rx_stop_bad, rx_parity_bad} = 3'b000;
        rx_char_data = 8'h00;
    end

    // Modem levels move just after an edge
    task automatic lines(input logic [3:0] v);
        @(posedge clk_sys);
        {dcd_in, ri_in, dsr_in, cts_in} <= v;
    endtask

    // Optional start bit, then the completed frame with flags {break, stop, parity}
    task automatic send(input logic [7:0] c, input logic [2:0] f, input bit st);
        @(posedge clk_sys);
        rx_start_valid <= st;
        @(posedge clk_sys);
        rx_start_valid <= 1'b0;
        rx_char_valid <= 1'b1;
        rx_char_data <= c;
        {rx_break_seen, rx_stop_bad, rx_parity_bad} <= f;
        @(posedge clk_sys);
        rx_char_valid <= 1'b0;
        // Inverted outside the pulse so stale data is never mistaken for good
        rx_char_data <= ~c;
        {rx_break_seen, rx_stop_bad, rx_parity_bad} <= ~f;
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the line and modem status block
module testbench
    import uart_status_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic  [9:0] io_addr = MODEM_STATUS_ADDR;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic  [7:0] io_wdata = 8'h00;
    logic  [7:0] interrupt_enable_reg = 8'h00;
    logic  [4:0] modem_ctrl = 5'h00;
    logic        fifo_mode_enable = 1'b0;
    logic        tx_load_take = 1'b0;
    logic        tx_shift_empty = 1'b1;
    logic  [7:0] io_rdata, tx_load_data, rx_char_data, d;
    logic        tx_load_valid, tx_empty_irq, modem_irq, dcd_in, ri_in, dsr_in, cts_in;
    logic        rx_char_valid, rx_parity_bad, rx_stop_bad, rx_break_seen, rx_start_valid;
    logic  [3:0] ms_eff = 4'h0;
    logic  [3:0] ms_delta = 4'h0;
    logic  [3:0] pv = 4'h0;
    logic [31:0] r;
    int          bad_count = 0;
    int          checked = 0;
    int          seed = 39578;
    int          q[$];
    bit          blocked = 1'b0;

    always #5 clk_sys = ~clk_sys;

    uart_line_modem_status #(.FIFO_DEPTH(16)) uut (
        .*, .rx_fifo_clear(1'b0), .tx_fifo_clear(1'b0), .line_irq());

    modem_partner md (.*);

    task automatic finish_test();
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Masked byte compare, counted
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checked++;
        if ((got & m) !== (exp & m))
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got & m, exp & m);
        end
    endtask

    // One I/O cycle; read data sampled mid-cycle, address parked on modem status
    task automatic acc(input logic [9:0] a, input bit w, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk_sys);
        io_addr <= a;
        io_rd <= !w;
        io_wr <= w;
        io_wdata <= wd;
        @(negedge clk_sys);
        rd = io_rdata;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        io_addr <= MODEM_STATUS_ADDR;
        io_wdata <= ~wd;
    endtask

    task automatic rdc(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] m);
        acc(a, 1'b0, 8'h00, d);
        chk(d, exp, m);
    endtask

    // Pin or loopback change, then flags, interrupt and clear on read
    task automatic modem(input logic [3:0] v, input logic [4:0] mc);
        logic [3:0] e;
        md.lines(v);
        modem_ctrl <= mc;
        e = mc[4] ? {mc[MC_OUT2], mc[MC_OUT1], mc[MC_DTR], mc[MC_RTS]} : v;
        ms_delta |= (e ^ ms_eff) & 4'b1011;
        ms_delta[MS_T_RI] |= ms_eff[2] & !e[2];
        ms_eff = e;
        repeat (8) @(negedge clk_sys);
        chk({7'h0, modem_irq}, {7'h0, interrupt_enable_reg[IE_MODEM] && |ms_delta}, 8'h01);
        rdc(MODEM_STATUS_ADDR, {ms_eff, ms_delta}, 8'hff);
        ms_delta = 4'h0;
        @(negedge clk_sys);
        chk({7'h0, modem_irq}, 8'h00, 8'h01);
        rdc(MODEM_STATUS_ADDR, {ms_eff, 4'h0}, 8'hff);
    endtask

    // Received character; the model drops it while a break blocks or the FIFO is full
    task automatic rx(input logic [7:0] c, input logic [2:0] f, input bit st);
        md.send(c, f, st);
        if (st)
            blocked = 1'b0;
        if (!blocked && q.size() < 16)
            q.push_back({f, c});
        blocked |= f[2];
        repeat (2) @(posedge clk_sys);
    endtask

    // First status read clears stale latches, second shows the top entry
    task automatic drain();
        int e;
        while (q.size() > 0)
        begin
            e = q.pop_front();
            rdc(LINE_STATUS_ADDR, 8'h01, 8'h01);
            rdc(LINE_STATUS_ADDR, {3'b011, e[10:8], 2'b01}, 8'h7f);
            rdc(RX_DATA_ADDR, e[7:0], 8'hff);
        end
        acc(LINE_STATUS_ADDR, 1'b0, 8'h00, d);
        rdc(LINE_STATUS_ADDR, 8'h60, 8'hff);
    endtask

    // Take one byte from the transmit side
    task automatic tk(input logic [7:0] x);
        @(negedge clk_sys);
        chk(tx_load_data, x, 8'hff);
        @(posedge clk_sys);
        tx_load_take <= 1'b1;
        @(posedge clk_sys);
        tx_load_take <= 1'b0;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(LINE_STATUS_ADDR, 8'h60, 8'hff);
        rdc(MODEM_STATUS_ADDR, DELTA_RST, 8'hff);
        rdc(SCRATCH_ADDR, SCRATCH_RST, 8'hff);
        r = $random(seed);
        acc(SCRATCH_ADDR, 1'b1, r[7:0], d);
        acc(10'h300, 1'b1, ~r[7:0], d);
        rdc(SCRATCH_ADDR, r[7:0], 8'hff);
        // Modem lines: ring edges, random pins, masking, then loopback
        interrupt_enable_reg <= 8'h08;
        modem(4'h4, 5'h00);
        modem(4'h0, 5'h00);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 3)
                interrupt_enable_reg <= 8'h00;
            r = $random(seed);
            pv = r[3:0];
            modem(pv, 5'h00);
        end
        interrupt_enable_reg <= 8'h08;
        for (int i = 0; i < 4; i++)
        begin
            r = $random(seed);
            modem(pv, {1'b1, r[3:0]});
        end
        modem(pv, 5'h00);
        // FIFO mode: error flags at top, break, overrun
        fifo_mode_enable <= 1'b1;
        rx(8'h5a, 3'b001, 1'b1);
        rx(8'ha5, 3'b010, 1'b1);
        rx(8'h3c, 3'b000, 1'b1);
        drain();
        rx(8'h00, 3'b100, 1'b1);
        rx(8'h00, 3'b100, 1'b0);
        rx(8'h77, 3'b000, 1'b0);
        rx(8'h66, 3'b000, 1'b1);
        drain();
        for (int i = 0; i < 17; i++)
        begin
            r = $random(seed);
            rx(r[7:0], 3'b000, 1'b1);
        end
        rdc(LINE_STATUS_ADDR, 8'h63, 8'h7f);
        drain();
        // Transmit FIFO filled past capacity while the far side stalls
        interrupt_enable_reg <= 8'h02;
        for (int i = 0; i < 17; i++)
            acc(TX_DATA_ADDR, 1'b1, 8'h10 + 8'(i), d);
        rdc(LINE_STATUS_ADDR, 8'h00, 8'h60);
        for (int i = 0; i < 16; i++)
            tk(8'h10 + 8'(i));
        rdc(LINE_STATUS_ADDR, 8'h60, 8'h60);
        chk({7'h0, tx_empty_irq}, 8'h01, 8'h01);
        acc(TX_DATA_ADDR, 1'b1, 8'hee, d);
        @(negedge clk_sys);
        chk({7'h0, tx_empty_irq}, 8'h00, 8'h01);
        tk(8'hee);
        repeat (2) @(negedge clk_sys);
        chk({7'h0, tx_empty_irq}, 8'h01, 8'h01);
        acc(INT_ID_ADDR, 1'b0, 8'h00, d);
        @(negedge clk_sys);
        chk({7'h0, tx_empty_irq}, 8'h00, 8'h01);
        // Legacy single buffer
        fifo_mode_enable <= 1'b0;
        interrupt_enable_reg <= 8'h00;
        acc(TX_DATA_ADDR, 1'b1, 8'h81, d);
        rdc(LINE_STATUS_ADDR, 8'h00, 8'h20);
        tk(8'h81);
        rdc(LINE_STATUS_ADDR, 8'h20, 8'h20);
        rx(8'h11, 3'b000, 1'b1);
        rx(8'h22, 3'b000, 1'b1);
        rdc(LINE_STATUS_ADDR, 8'h03, 8'h03);
        rdc(RX_DATA_ADDR, 8'h22, 8'hff);
        rdc(LINE_STATUS_ADDR, 8'h00, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            rx(8'h30 + 8'(k), 3'(1 << k), 1'b1);
            rdc(LINE_STATUS_ADDR, 8'(4 << k) | 8'h01, 8'h1d);
            rdc(RX_DATA_ADDR, 8'h30 + 8'(k), 8'hff);
        end
        finish_test();
    end
endmodule

bind uart_line_modem_status status_checker u_chk (.*);
